/* verilog/lvd_pkg.sv */
// constants, field layouts, types and threshold tables for the low voltage reset and detector block
// assumes a 32-bit classic wishbone register bus and millivolt-coded thresholds toward the analog comparators
package lvd_pkg;

  // register bus geometry
  localparam int          WB_ADR_W        = 8;
  localparam int          WB_DAT_W        = 32;
  localparam int          WB_SEL_W        = 4;

  // register indices; the byte address is four times the index
  localparam logic [5:0]  CTRL_IDX        = 6'h06;
  localparam logic [5:0]  IRQ_STATUS_IDX  = 6'h07;
  localparam logic [5:0]  IRQ_CLEAR_IDX   = 6'h08;
  localparam logic [5:0]  IRQ_ENABLE_IDX  = 6'h09;
  localparam logic [WB_ADR_W-1:0] CTRL_ADDR       = {CTRL_IDX, 2'h0};
  localparam logic [WB_ADR_W-1:0] IRQ_STATUS_ADDR = {IRQ_STATUS_IDX, 2'h0};
  localparam logic [WB_ADR_W-1:0] IRQ_CLEAR_ADDR  = {IRQ_CLEAR_IDX, 2'h0};
  localparam logic [WB_ADR_W-1:0] IRQ_ENABLE_ADDR = {IRQ_ENABLE_IDX, 2'h0};

  // detector control register fields
  localparam int          FLAG_BIT        = 6;
  localparam int          STATE_BIT       = 5;
  localparam int          CTRL_FIELD_HI   = 4;
  localparam int          CTRL_FIELD_W    = 5;

  // configuration word 0 layout
  localparam int          CFG_W           = 13;
  localparam int          CFG_RST_SEL_HI  = 8;
  localparam int          CFG_RST_SEL_LO  = 7;
  localparam logic [1:0]  RST_SEL_POR     = 2'h3;

  // sticky event bits
  localparam int          EV_W            = 3;
  localparam int          EV_DETECT       = 0;
  localparam int          EV_DIP          = 1;
  localparam int          EV_BROWNOUT     = 2;

  // timing
  localparam int          CLK_HZ          = 40000000;
  localparam int          BROWNOUT_NS     = 80000;
  localparam int          BROWNOUT_CYC    = (BROWNOUT_NS / 1000) * (CLK_HZ / 1000000);
  localparam int          CFG_SETTLE_CYC  = 2;

  // thresholds in millivolts
  localparam int          MV_W            = 13;

  typedef struct packed {
    logic       irq_en;
    logic       wake_en;
    logic       det_en;
    logic [1:0] level_sel;
  } ctrl_s;

  localparam ctrl_s       CTRL_RESET      = '{irq_en: 1'b0, wake_en: 1'b0, det_en: 1'b0, level_sel: 2'h0};

  typedef struct packed {
    logic [MV_W-1:0] reset_mv;
    logic [MV_W-1:0] release_mv;
  } reset_level_s;

  typedef enum logic [1:0] {SUPPLY_OK, DIP_HALT, BROWNOUT_RESET} brownout_e;

  // detect level per select code
  function automatic logic [MV_W-1:0] detect_mv(input logic [1:0] sel);
    case (sel)
      2'h3:    detect_mv = 13'd2200;
      2'h2:    detect_mv = 13'd3300;
      2'h1:    detect_mv = 13'd4000;
      default: detect_mv = 13'd4500;
    endcase
  endfunction

  // reset and release level per configuration code; code 11 gives zero levels, meaning power-on reset only
  function automatic reset_level_s reset_levels(input logic [1:0] sel);
    case (sel)
      2'h2:    reset_levels = '{reset_mv: 13'd2700, release_mv: 13'd2900};
      2'h1:    reset_levels = '{reset_mv: 13'd3500, release_mv: 13'd3700};
      2'h0:    reset_levels = '{reset_mv: 13'd4000, release_mv: 13'd4200};
      default: reset_levels = '{reset_mv: 13'd0, release_mv: 13'd0};
    endcase
  endfunction

endpackage

/* verilog/sync_2ff.sv */
// two flip-flop synchroniser for asynchronous level inputs
// assumes each bit is an independent slow level; multi-bit words need their own settling
`timescale 1ns/1ps
module sync_2ff #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta     <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // sync_2ff

/* verilog/low_voltage_reset_and_detect.sv */
// low voltage reset selection, low voltage detector control register, brown-out timing and interrupt status
// assumes analog comparators outside that report supply below the levels given here, and a wishbone master
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps

// Function
// - reset level select comes from config word 0 bits; code 11 means power-on only
// - reset/release levels: 10 is 2.7/2.9V, 01 is 3.5/3.7V, 00 is 4.0/4.2V
// - control register: flag bit6, state bit5, irq en bit4, wake bit3, enable bit2, level 1:0
// - state bit is read-only: 0 at or below detect level, else 1
// - detect level select: 11 2.2V, 10 3.3V, 01 4.0V, 00 4.5V
// - enable low turns detector off and forces state bit to 1
// - supply falling below detect level sets the interrupt flag
// - flag stays 0 while supply remains above the detect level
// - flag with irq enable and global enable requests the interrupt vector
// - interrupt enable bit is readable and writable; 1 enables detector interrupt
// - wake enable 1 lets a detection wake from sleep or idle; 0 does not
// - detector keeps running in sleep; a crossing sets flag and, with wake enable 1, wakes
// - flag stays set until software clears it; any system reset clears it
// - dip below reset level under 80us keeps registers and halts, clock running
// - dip below reset level over 80us produces a full system reset
module low_voltage_reset_and_detect
  import lvd_pkg::*;
#(
  parameter int BROWNOUT_CYCLES = BROWNOUT_CYC
) (
  // clock and reset
  input  wire logic                SYS_CLK,
  input  wire logic                RESET,
  // wishbone slave
  input  wire logic                WB_CYC_I,
  input  wire logic                WB_STB_I,
  input  wire logic                WB_WE_I,
  input  wire logic [WB_ADR_W-1:0] WB_ADR_I,
  input  wire logic [WB_SEL_W-1:0] WB_SEL_I,
  input  wire logic [WB_DAT_W-1:0] WB_DAT_I,
  output logic      [WB_DAT_W-1:0] WB_DAT_O,
  output logic                     WB_ACK_O,
  // configuration word and cpu status
  input  wire logic [CFG_W-1:0]    CONFIG_WORD0,
  input  wire logic                GLOBAL_IRQ_EN,
  // analog comparators
  input  wire logic                SUPPLY_BELOW_DETECT,
  input  wire logic                SUPPLY_BELOW_RESET,
  output logic                     DETECTOR_POWER_EN,
  output logic                     RESET_DETECTOR_EN,
  output logic      [MV_W-1:0]     DETECT_THRESHOLD_MV,
  output logic      [MV_W-1:0]     RESET_THRESHOLD_MV,
  output logic      [MV_W-1:0]     RELEASE_THRESHOLD_MV,
  // to the core
  output logic                     VECTOR_REQ,
  output logic                     WAKE_REQ,
  output logic                     CORE_HALT,
  output logic                     SYS_RESET_REQ,
  output logic                     IRQ
);

  localparam int CNT_W = $clog2(BROWNOUT_CYCLES + 1);

  // elaboration check
  if (BROWNOUT_CYCLES < 1)
  begin : g_bad_count
    $error("BROWNOUT_CYCLES must be at least one");
  end

  logic                    below_detect_async;
  logic                    below_reset_async;
  logic [1:0]              cmp_sync;
  logic                    below_detect;
  logic                    below_reset;
  logic [1:0]              cfg_sel_sync;
  logic [1:0]              cfg_sel;
  logic                    cfg_loaded;
  logic [1:0]              cfg_wait;
  ctrl_s                   ctrl;
  logic                    irq_flag;
  logic                    det_low;
  logic                    det_low_q;
  logic                    detect_event;
  logic [EV_W-1:0]         irq_status;
  logic [EV_W-1:0]         irq_enable;
  logic [EV_W-1:0]         ev;
  logic [EV_W-1:0]         clear_mask;
  brownout_e               state;
  brownout_e               next_state;
  logic [CNT_W-1:0]        dip_cnt;
  logic                    reset_armed;
  logic                    below_armed;
  logic                    bus_req;
  logic                    bus_wr;
  logic                    supply_ok_state;
  logic [WB_DAT_W-1:0]     next_rdata;
  reset_level_s            rst_lv;

  assign below_detect_async = SUPPLY_BELOW_DETECT;
  assign below_reset_async  = SUPPLY_BELOW_RESET;

  // comparator outputs are asynchronous to the system clock
  sync_2ff #(
    .WIDTH    (2)
  ) u_cmp_sync (
    .clk      (SYS_CLK),
    .rst      (RESET),
    .async_in ({below_reset_async, below_detect_async}),
    .sync_out (cmp_sync)
  );
  assign below_detect = cmp_sync[0];
  assign below_reset  = cmp_sync[1];

  // the config word is a static strap, still synchronised since it enters from outside the clock domain
  sync_2ff #(
    .WIDTH    (2)
  ) u_cfg_sync (
    .clk      (SYS_CLK),
    .rst      (RESET),
    .async_in (CONFIG_WORD0[CFG_RST_SEL_HI:CFG_RST_SEL_LO]),
    .sync_out (cfg_sel_sync)
  );

  // strap capture after reset release; until then only power-on reset applies
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      cfg_sel    <= RST_SEL_POR;
      cfg_loaded <= 1'b0;
      cfg_wait   <= 2'h0;
    end
    else if (!cfg_loaded)
    begin
      if (cfg_wait == 2'(CFG_SETTLE_CYC))
      begin
        cfg_sel    <= cfg_sel_sync;
        cfg_loaded <= 1'b1;
      end
      else
      begin
        cfg_wait <= cfg_wait + 2'h1;
      end
    end
  end

  // reset and detect thresholds toward the comparators
  assign rst_lv = reset_levels(cfg_sel);
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      DETECT_THRESHOLD_MV  <= '0;
      RESET_THRESHOLD_MV   <= '0;
      RELEASE_THRESHOLD_MV <= '0;
      RESET_DETECTOR_EN    <= 1'b0;
      DETECTOR_POWER_EN    <= 1'b0;
    end
    else
    begin
      DETECT_THRESHOLD_MV  <= detect_mv(ctrl.level_sel);
      RESET_THRESHOLD_MV   <= rst_lv.reset_mv;
      RELEASE_THRESHOLD_MV <= rst_lv.release_mv;
      RESET_DETECTOR_EN    <= reset_armed;
      DETECTOR_POWER_EN    <= ctrl.det_en;
    end
  end

  // bus decode; a write lands on the edge where the master samples ack
  assign bus_req = WB_CYC_I && WB_STB_I;
  assign bus_wr  = bus_req && WB_WE_I && WB_ACK_O && WB_SEL_I[0];

  // detector state: disabled detector always reads as supply fine
  assign det_low         = ctrl.det_en && below_detect;
  assign supply_ok_state = !det_low;
  assign detect_event    = det_low && !det_low_q;

  // control field; only the low byte lane carries data
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      ctrl <= CTRL_RESET;
    end
    else if (bus_wr && WB_ADR_I == CTRL_ADDR)
    begin
      ctrl <= ctrl_s'(WB_DAT_I[CTRL_FIELD_HI:0]);
    end
  end

  // edge memory so a long dip sets the flag once, not every cycle after a software clear
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      det_low_q <= 1'b0;
    end
    else
    begin
      det_low_q <= det_low;
    end
  end

  // sticky detector flag: brown-out reset clears, then a new event wins over a software clear
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      irq_flag <= 1'b0;
    end
    else if (state == BROWNOUT_RESET)
    begin
      irq_flag <= 1'b0;
    end
    else if (detect_event)
    begin
      irq_flag <= 1'b1;
    end
    else if (bus_wr && WB_ADR_I == CTRL_ADDR && !WB_DAT_I[FLAG_BIT])
    begin
      irq_flag <= 1'b0;
    end
  end

  // requests to the core; detector is not gated by sleep so it wakes the device
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      VECTOR_REQ <= 1'b0;
      WAKE_REQ   <= 1'b0;
    end
    else
    begin
      VECTOR_REQ <= irq_flag && ctrl.irq_en && GLOBAL_IRQ_EN;
      WAKE_REQ   <= irq_flag && ctrl.wake_en;
    end
  end

  // brown-out sequencing only runs once a reset level is configured
  assign reset_armed = cfg_loaded && (cfg_sel != RST_SEL_POR);
  assign below_armed = reset_armed && below_reset;

  always_comb
  begin
    next_state = state;
    case (state)
      SUPPLY_OK:
      begin
        if (below_armed)
        begin
          next_state = DIP_HALT;
        end
      end
      DIP_HALT:
      begin
        if (!below_armed)
        begin
          next_state = SUPPLY_OK;
        end
        else if (dip_cnt == CNT_W'(BROWNOUT_CYCLES - 1))
        begin
          next_state = BROWNOUT_RESET;
        end
      end
      BROWNOUT_RESET:
      begin
        // held until the comparator, with its release hysteresis, reports recovery
        if (!below_armed)
        begin
          next_state = SUPPLY_OK;
        end
      end
      default:
      begin
        next_state = SUPPLY_OK;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      state <= SUPPLY_OK;
    end
    else
    begin
      state <= next_state;
    end
  end

  // dip duration counter restarts on every recovery
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      dip_cnt <= '0;
    end
    else if (state == DIP_HALT && below_armed)
    begin
      dip_cnt <= dip_cnt + CNT_W'(1);
    end
    else
    begin
      dip_cnt <= '0;
    end
  end

  // halt keeps register contents and leaves the oscillator alone; reset request goes to the reset tree
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      CORE_HALT     <= 1'b0;
      SYS_RESET_REQ <= 1'b0;
    end
    else
    begin
      CORE_HALT     <= (next_state != SUPPLY_OK);
      SYS_RESET_REQ <= (next_state == BROWNOUT_RESET);
    end
  end

  // interrupt status events
  assign ev[EV_DETECT]   = detect_event;
  assign ev[EV_DIP]      = (state == SUPPLY_OK) && (next_state == DIP_HALT);
  assign ev[EV_BROWNOUT] = (state == DIP_HALT) && (next_state == BROWNOUT_RESET);
  assign clear_mask      = (bus_wr && WB_ADR_I == IRQ_CLEAR_ADDR) ? WB_DAT_I[EV_W-1:0] : '0;

  // sticky bits; a set in the clearing cycle wins
  for (genvar i = 0; i < EV_W; i++)
  begin : g_status
    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
      if (RESET)
      begin
        irq_status[i] <= 1'b0;
      end
      else if (ev[i])
      begin
        irq_status[i] <= 1'b1;
      end
      else if (clear_mask[i])
      begin
        irq_status[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      irq_enable <= '0;
    end
    else if (bus_wr && WB_ADR_I == IRQ_ENABLE_ADDR)
    begin
      irq_enable <= WB_DAT_I[EV_W-1:0];
    end
  end

  // level interrupt straight from the two registers
  assign IRQ = |(irq_status & irq_enable);

  // read mux; unmapped and write-only addresses read zero
  always_comb
  begin
    next_rdata = '0;
    case (WB_ADR_I)
      CTRL_ADDR:
      begin
        next_rdata[FLAG_BIT]          = irq_flag;
        next_rdata[STATE_BIT]         = supply_ok_state;
        next_rdata[CTRL_FIELD_HI:0]   = ctrl;
      end
      IRQ_STATUS_ADDR:
      begin
        next_rdata[EV_W-1:0] = irq_status;
      end
      IRQ_ENABLE_ADDR:
      begin
        next_rdata[EV_W-1:0] = irq_enable;
      end
      default:
      begin
        next_rdata = '0;
      end
    endcase
  end

  // one-wait-state ack; every address answers so the master never hangs
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= '0;
    end
    else
    begin
      WB_ACK_O <= bus_req && !WB_ACK_O;
      if (bus_req && !WB_ACK_O && !WB_WE_I)
      begin
        WB_DAT_O <= next_rdata;
      end
    end
  end

endmodule // low_voltage_reset_and_detect

/* testbench/cpu_core_model.sv */
// core stand-in: global interrupt enable, vector entry and wake detection
// assumes the block's request outputs are levels on the same clock
`timescale 1ns/1ps
module cpu_core_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // from software and the block
  input  wire logic       global_irq_enable_instr,
  input  wire logic       vector_req,
  input  wire logic       wake_req,
  // to the block and the bench
  output logic            global_irq_en,
  output logic [7:0]      vectors,
  output logic            woke
);
  // entry drops the global enable, so one flag gives one vector
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      global_irq_en <= 1'b0;
      vectors       <= 8'h00;
    end
    else if (vector_req && global_irq_en)
    begin
      global_irq_en <= 1'b0;
      vectors       <= vectors + 8'h01;
    end
    else if (global_irq_enable_instr)
      global_irq_en <= 1'b1;
  end

  // sticky wake seen, kept until reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      woke <= 1'b0;
    else if (wake_req)
      woke <= 1'b1;
  end
endmodule // cpu_core_model

/* testbench/low_voltage_reset_and_detect_props.sv */
// checker for the low voltage block: bus answer, interrupt gating, dip timing
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module low_voltage_reset_and_detect_props
  import lvd_pkg::*;
#(
  parameter int BROWNOUT_CYCLES = BROWNOUT_CYC
) (
  // clock and reset
  input  wire logic            SYS_CLK,
  input  wire logic            RESET,
  // bus
  input  wire logic            WB_CYC_I,
  input  wire logic            WB_STB_I,
  input  wire logic            WB_ACK_O,
  // core and supply
  input  wire logic            GLOBAL_IRQ_EN,
  input  wire logic            SUPPLY_BELOW_RESET,
  input  wire logic            VECTOR_REQ,
  input  wire logic            CORE_HALT,
  input  wire logic            SYS_RESET_REQ,
  input  wire logic [MV_W-1:0] RESET_THRESHOLD_MV,
  input  wire logic [MV_W-1:0] RELEASE_THRESHOLD_MV
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  int halt_cnt;
  // halted cycles short of reset; restarts on recovery so short dips never add up
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
      halt_cnt <= 0;
    else if (CORE_HALT && !SYS_RESET_REQ)
      halt_cnt <= halt_cnt + 1;
    else
      halt_cnt <= 0;
  end

  sequence bus_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence

  sequence ack_pulse;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence

  a_ack_answer: assert property (bus_req |=> ack_pulse)
    else $error("ack late or longer than one cycle");
  a_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without a request");
  a_vector_gate: assert property ($rose(VECTOR_REQ) |-> $past(GLOBAL_IRQ_EN))
    else $error("vector request without global enable");
  a_halt_sync: assert property ($rose(CORE_HALT) |-> $past(SUPPLY_BELOW_RESET, 2))
    else $error("halt before synchronised dip");
  a_brown_halts: assert property (SYS_RESET_REQ |-> CORE_HALT)
    else $error("reset request without halt");
  a_dip_bound: assert property (CORE_HALT && !SYS_RESET_REQ |-> halt_cnt < BROWNOUT_CYCLES)
    else $error("dip lasted past terminal count");
  a_dip_full: assert property ($rose(SYS_RESET_REQ) |-> halt_cnt == BROWNOUT_CYCLES)
    else $error("reset request before terminal count");
  a_brown_hold: assert property ($fell(SYS_RESET_REQ) |-> !$past(SUPPLY_BELOW_RESET, 2))
    else $error("reset request dropped while supply low");
  a_release_gap: assert property (RESET_THRESHOLD_MV != 13'h0 |-> RELEASE_THRESHOLD_MV == RESET_THRESHOLD_MV + 13'hc8)
    else $error("release level not reset level plus hysteresis");
endmodule // low_voltage_reset_and_detect_props

bind low_voltage_reset_and_detect low_voltage_reset_and_detect_props #(
  .BROWNOUT_CYCLES(BROWNOUT_CYCLES)
) props_u (
  .SYS_CLK(SYS_CLK),
  .RESET(RESET),
  .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I),
  .WB_ACK_O(WB_ACK_O),
  .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN),
  .SUPPLY_BELOW_RESET(SUPPLY_BELOW_RESET),
  .VECTOR_REQ(VECTOR_REQ),
  .CORE_HALT(CORE_HALT),
  .SYS_RESET_REQ(SYS_RESET_REQ),
  .RESET_THRESHOLD_MV(RESET_THRESHOLD_MV),
  .RELEASE_THRESHOLD_MV(RELEASE_THRESHOLD_MV)
);

/* testbench/low_voltage_reset_and_detect_tb_top.sv */
// bench for the low voltage block: register tests, detector, interrupt path, supply dips
// assumes the checker binds itself and the core stand-in drives the global enable
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); end end
module low_voltage_reset_and_detect_tb_top
  import lvd_pkg::*;
;
  logic        SYS_CLK = 1'b0;
  logic        RESET = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [12:0] cfg = 13'h1fff;
  logic        below_det = 1'b0;
  logic        below_rst = 1'b0;
  logic        global_irq_enable_instr = 1'b0;
  logic [31:0] rdat;
  logic [12:0] det_mv, rst_mv, rel_mv;
  logic        ack, gie, det_pwr, rst_en, vec_req, wake_req, halt, sysrst, irq, woke;
  logic [7:0]  vectors;
  int          failures = 0;
  int          compares = 0;
  // levels in mV, indexed by select code
  logic [12:0] det_tab [4] = '{13'h1194, 13'hfa0, 13'hce4, 13'h898};
  logic [12:0] rst_tab [4] = '{13'hfa0, 13'hdac, 13'ha8c, 13'h0};
  logic [12:0] rel_tab [4] = '{13'h1068, 13'he74, 13'hb54, 13'h0};

  always #12.5 SYS_CLK = ~SYS_CLK;

  // small terminal count keeps the long dip short
  low_voltage_reset_and_detect #(.BROWNOUT_CYCLES(8)) dut_u (
    .SYS_CLK(SYS_CLK), .RESET(RESET), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .CONFIG_WORD0(cfg), .GLOBAL_IRQ_EN(gie), .SUPPLY_BELOW_DETECT(below_det),
    .SUPPLY_BELOW_RESET(below_rst), .DETECTOR_POWER_EN(det_pwr), .RESET_DETECTOR_EN(rst_en),
    .DETECT_THRESHOLD_MV(det_mv), .RESET_THRESHOLD_MV(rst_mv), .RELEASE_THRESHOLD_MV(rel_mv),
    .VECTOR_REQ(vec_req), .WAKE_REQ(wake_req), .CORE_HALT(halt), .SYS_RESET_REQ(sysrst), .IRQ(irq));

  cpu_core_model core_u (
    .clk(SYS_CLK), .rst(RESET), .global_irq_enable_instr(global_irq_enable_instr),
    .vector_req(vec_req), .wake_req(wake_req),
    .global_irq_en(gie), .vectors(vectors), .woke(woke));

  task automatic tick(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask

  // one classic cycle; ack is read before this edge's updates land, so no race
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int t = 0;
    @(posedge SYS_CLK);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    @(posedge SYS_CLK);
    while (ack !== 1'b1 && t < 50)
    begin
      @(posedge SYS_CLK);
      t++;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (t >= 50)
      failures++;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask

  task automatic do_reset();
    RESET <= 1'b1;
    tick(4);
    RESET <= 1'b0;
  endtask

  task automatic wrap_up();
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // main sequence; ends on code 10 so dips are armed
  initial
  begin
    logic [1:0] c;
    for (int i = 0; i < 4; i++)
    begin
      c = 2'(i + 3);
      cfg <= {4'hf, c, 7'h7f};
      do_reset();
      tick(8);
      `CHK(rst_mv, rst_tab[c])
      `CHK(rel_mv, rel_tab[c])
      `CHK(rst_en, c != 2'h3)
    end
    rd(CTRL_ADDR, 32'h20);
    rd(IRQ_STATUS_ADDR, 32'h0);
    rd(IRQ_CLEAR_ADDR, 32'h0);
    wr(8'h40, 32'hff);
    rd(8'h40, 32'h0);
    for (int s = 0; s < 4; s++)
    begin
      wr(CTRL_ADDR, 32'(s));
      tick(2);
      `CHK(det_mv, det_tab[s])
    end
    wr(CTRL_ADDR, 32'h1a);
    below_det <= 1'b1;
    tick(6);
    rd(CTRL_ADDR, 32'h3a);
    wr(CTRL_ADDR, 32'h1e);
    tick(6);
    rd(CTRL_ADDR, 32'h5e);
    `CHK(det_pwr, 1'b1)
    `CHK(wake_req, 1'b1)
    `CHK(vec_req, 1'b0)
    global_irq_enable_instr <= 1'b1;
    tick(1);
    global_irq_enable_instr <= 1'b0;
    tick(6);
    `CHK(vectors, 8'h01)
    `CHK(woke, 1'b1)
    rd(IRQ_STATUS_ADDR, 32'h1);
    `CHK(irq, 1'b0)
    wr(IRQ_ENABLE_ADDR, 32'h1);
    tick(1);
    `CHK(irq, 1'b1)
    wr(IRQ_CLEAR_ADDR, 32'h1);
    tick(1);
    `CHK(irq, 1'b0)
    wr(CTRL_ADDR, 32'h1e);
    tick(4);
    rd(CTRL_ADDR, 32'h1e);
    below_det <= 1'b0;
    tick(6);
    rd(CTRL_ADDR, 32'h3e);
    below_det <= 1'b1;
    tick(6);
    below_det <= 1'b0;
    tick(6);
    rd(CTRL_ADDR, 32'h7e);
    below_rst <= 1'b1;
    tick(5);
    `CHK(halt, 1'b1)
    below_rst <= 1'b0;
    tick(6);
    `CHK(sysrst, 1'b0)
    rd(CTRL_ADDR, 32'h7e);
    below_rst <= 1'b1;
    tick(20);
    `CHK(sysrst, 1'b1)
    below_rst <= 1'b0;
    tick(6);
    `CHK(halt, 1'b0)
    rd(CTRL_ADDR, 32'h3e);
    rd(IRQ_STATUS_ADDR, 32'h7);
    // raise the flag again so the system reset below has something to clear
    below_det <= 1'b1;
    tick(6);
    below_det <= 1'b0;
    tick(6);
    rd(CTRL_ADDR, 32'h7e);
    do_reset();
    rd(CTRL_ADDR, 32'h20);
    rd(IRQ_STATUS_ADDR, 32'h0);
    wrap_up();
  end

  // watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (5000) @(posedge SYS_CLK);
    failures++;
    wrap_up();
  end
endmodule // low_voltage_reset_and_detect_tb_top
